//--- design/amc_pkg.sv
// Package of constants and types for the asynchronous memory port controller.
package amc_pkg;

    // ****************************************************************
    // Widths and pin encodings
    // ****************************************************************
    localparam int ADDR_W       = 23;
    localparam int DIE_ADDR_W   = 21;
    localparam int DATA_W       = 8;
    localparam int DIE_N        = 4;
    localparam int DIE_SEL_HI   = 22;
    localparam int DIE_SEL_LO   = 21;
    localparam logic [3:0] SEL_NONE = 4'hf;

    // ****************************************************************
    // Timing, in nanoseconds (wake in microseconds, power-up in milliseconds), and the clock period
    // ****************************************************************
    localparam int CLK_NS        = 4;
    localparam int ACCESS_NS     = 50;
    localparam int WRITE_NS      = 50;
    localparam int WAKE_US       = 100;
    localparam int POWERUP_MS    = 2;
    localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_CYC     = (WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC      = (WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int POWERUP_CYC   = (POWERUP_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 20;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

    typedef enum logic [1:0] {
        AMC_CMD_READ,
        AMC_CMD_WRITE,
        AMC_CMD_SLEEP,
        AMC_CMD_WAKE
    } amc_cmd_t;

    // Die number for the two top address bits under the global select.
    function automatic logic [1:0] amc_die_of(input logic [1:0] top);
        case (top)
            2'h0:    amc_die_of = 2'h0;
            2'h1:    amc_die_of = 2'h1;
            2'h2:    amc_die_of = 2'h3;
            default: amc_die_of = 2'h2;
        endcase
    endfunction : amc_die_of

endpackage : amc_pkg

//--- design/amc_timer_if.sv
// Interface between the controller and its wait timer.
`timescale 1ns/100ps
interface amc_timer_if;
    logic                          load;
    logic [amc_pkg::CNT_W-1:0]     count;
    logic                          done;
    modport ctrl  (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface : amc_timer_if

//--- design/amc_timer.sv
// Down-counting wait timer for the controller.
`timescale 1ns/100ps
module amc_timer (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    amc_timer_if.timer  tmr
);
    logic [amc_pkg::CNT_W-1:0] cnt_reg;
    logic [amc_pkg::CNT_W-1:0] cnt_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        if (tmr.load)
        begin
            cnt_next = tmr.count;
        end
        else if (cnt_reg != '0)
        begin
            cnt_next = cnt_reg - amc_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    assign tmr.done = (cnt_reg == '0) && !tmr.load;
endmodule : amc_timer

//--- design/amc_host.sv
// Host controller that drives the asynchronous byte-wide memory module pins.
//
// How it works
// (R1) Global select uses top bits for die
// (R2) Never drive two die selects low
// (R3) Low address bits pick byte in die
// (R4) Sleep_reset high makes device ignore inputs
// (R5) Nothing selected: device idles, bus floats
// (R6) Device floats bus unless gate low, strobe high
// (R7) Read needs strobe high and gate low
// (R8) Sample data after access time from last change
// (R9) Address reads spaced by read cycle time
// (R10) Select read holds address, gate, strobe
// (R11) Write: strobe low, host drives the data
// (R12) Device stores check bits on every write
// (R13) Multi error flag sampled in valid window
// (R14) Flag is open drain, pulled up outside
// (R15) Touch every die before trusting the flag
// (R16) Selects high, drop sleep, wait 100 us
// (R17) Hold selects and strobe high 2 ms
// (R18) Never combine global and die selects
`timescale 1ns/100ps
module amc_host #(
    parameter int POWERUP_CYCLES = amc_pkg::POWERUP_CYC,
    parameter int WAKE_CYCLES    = amc_pkg::WAKE_CYC,
    parameter int ACCESS_CYCLES  = amc_pkg::ACCESS_CYC,
    parameter int WRITE_CYCLES   = amc_pkg::WRITE_CYC
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_req_valid,
    output logic                               o_req_ready,
    input  wire amc_pkg::amc_cmd_t             i_req_cmd,
    input  wire logic                          i_req_global,
    input  wire logic [amc_pkg::ADDR_W-1:0]    i_req_addr,
    input  wire logic [amc_pkg::DATA_W-1:0]    i_req_wdata,
    output logic                               o_rsp_valid,
    output logic [amc_pkg::DATA_W-1:0]         o_rsp_rdata,
    output logic                               o_rsp_multi_err,
    output logic                               o_flag_trusted,
    output logic [amc_pkg::ADDR_W-1:0]         o_addr,
    output logic [amc_pkg::DIE_N-1:0]          o_die_select_n,
    output logic                               o_global_select_n,
    output logic                               o_write_strobe_n,
    output logic                               o_output_gate_n,
    output logic                               o_sleep_reset,
    input  wire logic [amc_pkg::DATA_W-1:0]    i_dq,
    output logic [amc_pkg::DATA_W-1:0]         o_dq,
    output logic                               o_dq_oe,
    input  wire logic                          i_multi_error_flag
);
    // ****************************************************************
    // State and registers
    // ****************************************************************
    typedef enum logic [2:0] {
        AMC_POWERUP,
        AMC_INIT,
        AMC_IDLE,
        AMC_READ,
        AMC_WRITE,
        AMC_RECOVER,
        AMC_SLEEP,
        AMC_WAKE
    } amc_state_t;

    amc_state_t                      st_reg, st_next;
    logic [amc_pkg::ADDR_W-1:0]      addr_reg, addr_next;
    logic [amc_pkg::DIE_N-1:0]       sel_n_reg, sel_n_next;
    logic                            gsel_n_reg, gsel_n_next;
    logic                            we_n_reg, we_n_next;
    logic                            oe_n_reg, oe_n_next;
    logic                            sleep_reg, sleep_next;
    logic [amc_pkg::DATA_W-1:0]      wdat_reg, wdat_next;
    logic                            dq_oe_reg, dq_oe_next;
    logic                            rv_reg, rv_next;
    logic [amc_pkg::DATA_W-1:0]      rdat_reg, rdat_next;
    logic                            merr_reg, merr_next;
    logic [amc_pkg::DIE_N-1:0]       seen_reg, seen_next;
    logic [1:0]                      die_reg, die_next;
    logic                            start_reg;

    amc_timer_if tif();

    amc_timer u_timer (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .tmr   (tif)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        st_next     = st_reg;
        addr_next   = addr_reg;
        sel_n_next  = sel_n_reg;
        gsel_n_next = gsel_n_reg;
        we_n_next   = we_n_reg;
        oe_n_next   = oe_n_reg;
        sleep_next  = sleep_reg;
        wdat_next   = wdat_reg;
        dq_oe_next  = dq_oe_reg;
        rv_next     = 1'b0;
        rdat_next   = rdat_reg;
        merr_next   = merr_reg;
        seen_next   = seen_reg;
        die_next    = die_reg;
        tif.load    = 1'b0;
        tif.count   = '0;
        case (st_reg)
            AMC_POWERUP:
            begin
                // (R17) Startup hold high
                if (start_reg)
                begin
                    tif.load = 1'b1;
                    tif.count = amc_pkg::CNT_W'(POWERUP_CYCLES);
                end
                else if (tif.done)
                begin
                    st_next = AMC_INIT;
                    die_next = 2'h0;
                end
            end
            AMC_INIT:
            begin
                // (R15) Touch each die
                if (sel_n_reg == amc_pkg::SEL_NONE)
                begin
                    sel_n_next = ~(4'h1 << die_reg);
                    oe_n_next = 1'b0;
                    tif.load = 1'b1;
                    tif.count = amc_pkg::CNT_W'(ACCESS_CYCLES);
                end
                else if (tif.done)
                begin
                    sel_n_next = amc_pkg::SEL_NONE;
                    oe_n_next = 1'b1;
                    seen_next = seen_reg | ~sel_n_reg;
                    die_next = die_reg + 2'h1;
                    if (die_reg == 2'h3)
                    begin
                        st_next = AMC_IDLE;
                    end
                end
            end
            AMC_IDLE:
            begin
                if (i_req_valid)
                begin
                    addr_next = i_req_addr;
                    wdat_next = i_req_wdata;
                    case (i_req_cmd)
                        amc_pkg::AMC_CMD_SLEEP:
                        begin
                            // (R4) Enter sleep
                            sleep_next = 1'b1;
                            seen_next = '0;
                            st_next = AMC_SLEEP;
                        end
                        amc_pkg::AMC_CMD_WAKE:
                        begin
                            st_next = AMC_IDLE;
                        end
                        default:
                        begin
                            // (R18) One select style only
                            if (i_req_global)
                            begin
                                // (R1) Top bits pick die
                                gsel_n_next = 1'b0;
                                seen_next = seen_reg | (4'h1 << amc_pkg::amc_die_of(
                                    i_req_addr[amc_pkg::DIE_SEL_HI:amc_pkg::DIE_SEL_LO]));
                            end
                            else
                            begin
                                // (R2) One-hot die select
                                sel_n_next = ~(4'h1 << i_req_addr[amc_pkg::DIE_SEL_HI:
                                    amc_pkg::DIE_SEL_LO]);
                                seen_next = seen_reg | ~sel_n_next;
                            end
                            tif.load = 1'b1;
                            if (i_req_cmd == amc_pkg::AMC_CMD_WRITE)
                            begin
                                // (R11) Write drives data
                                we_n_next = 1'b0;
                                dq_oe_next = 1'b1;
                                tif.count = amc_pkg::CNT_W'(WRITE_CYCLES);
                                st_next = AMC_WRITE;
                            end
                            else
                            begin
                                // (R7) Read with gate low
                                oe_n_next = 1'b0;
                                tif.count = amc_pkg::CNT_W'(ACCESS_CYCLES);
                                st_next = AMC_READ;
                            end
                        end
                    endcase
                end
            end
            AMC_READ:
            begin
                // (R8) (R10) Sample after access
                if (tif.done)
                begin
                    rv_next = 1'b1;
                    rdat_next = i_dq;
                    // (R13) (R14) Low flag, valid window
                    merr_next = !i_multi_error_flag;
                    sel_n_next = amc_pkg::SEL_NONE;
                    gsel_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    st_next = AMC_RECOVER;
                end
            end
            AMC_WRITE:
            begin
                // (R11) End write on strobe
                if (tif.done)
                begin
                    we_n_next = 1'b1;
                    st_next = AMC_RECOVER;
                end
            end
            AMC_RECOVER:
            begin
                // (R9) Space cycles apart
                sel_n_next = amc_pkg::SEL_NONE;
                gsel_n_next = 1'b1;
                dq_oe_next = 1'b0;
                st_next = AMC_IDLE;
            end
            AMC_SLEEP:
            begin
                if (i_req_valid && i_req_cmd == amc_pkg::AMC_CMD_WAKE)
                begin
                    // (R16) Release then wait
                    sleep_next = 1'b0;
                    tif.load = 1'b1;
                    tif.count = amc_pkg::CNT_W'(WAKE_CYCLES);
                    st_next = AMC_WAKE;
                end
            end
            default:
            begin
                if (tif.done)
                begin
                    die_next = 2'h0;
                    st_next = AMC_INIT;
                end
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg     <= AMC_POWERUP;
            addr_reg   <= '0;
            sel_n_reg  <= amc_pkg::SEL_NONE;
            gsel_n_reg <= 1'b1;
            we_n_reg   <= 1'b1;
            oe_n_reg   <= 1'b1;
            sleep_reg  <= 1'b0;
            wdat_reg   <= '0;
            dq_oe_reg  <= 1'b0;
            rv_reg     <= 1'b0;
            rdat_reg   <= '0;
            merr_reg   <= 1'b0;
            seen_reg   <= '0;
            die_reg    <= 2'h0;
        end
        else
        begin
            st_reg     <= st_next;
            addr_reg   <= addr_next;
            sel_n_reg  <= sel_n_next;
            gsel_n_reg <= gsel_n_next;
            we_n_reg   <= we_n_next;
            oe_n_reg   <= oe_n_next;
            sleep_reg  <= sleep_next;
            wdat_reg   <= wdat_next;
            dq_oe_reg  <= dq_oe_next;
            rv_reg     <= rv_next;
            rdat_reg   <= rdat_next;
            merr_reg   <= merr_next;
            seen_reg   <= seen_next;
            die_reg    <= die_next;
        end
    end

    // The power-up wait starts from reset: the timer loads on the first cycle.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            start_reg <= 1'b1;
        end
        else
        begin
            start_reg <= 1'b0;
        end
    end

    assign o_req_ready       = (st_reg == AMC_IDLE) || (st_reg == AMC_SLEEP);
    assign o_rsp_valid       = rv_reg;
    assign o_rsp_rdata       = rdat_reg;
    assign o_rsp_multi_err   = merr_reg;
    assign o_flag_trusted    = (seen_reg == amc_pkg::SEL_NONE);
    assign o_addr            = addr_reg;
    assign o_die_select_n    = sel_n_reg;
    assign o_global_select_n = gsel_n_reg;
    assign o_write_strobe_n  = we_n_reg;
    assign o_output_gate_n   = oe_n_reg;
    assign o_sleep_reset     = sleep_reg;
    assign o_dq              = wdat_reg;
    assign o_dq_oe           = dq_oe_reg;
endmodule : amc_host

//--- tb/amc_host_properties.sv
// Pin assertions for the memory port controller.
`timescale 1ns/100ps
module amc_host_properties #(
    parameter int WAKE_CYCLES   = 25000,
    parameter int ACCESS_CYCLES = 13,
    parameter int WRITE_CYCLES  = 13
) (
    input wire logic              i_clk,
    input wire logic              i_rst,
    input wire logic              i_req_valid,
    input wire logic              o_req_ready,
    input wire amc_pkg::amc_cmd_t i_req_cmd,
    input wire logic              o_rsp_valid,
    input wire logic              o_flag_trusted,
    input wire logic [22:0]       o_addr,
    input wire logic [3:0]        o_die_select_n,
    input wire logic              o_global_select_n,
    input wire logic              o_write_strobe_n,
    input wire logic              o_output_gate_n,
    input wire logic              o_sleep_reset,
    input wire logic              o_dq_oe
);
    localparam int RSP_LAT = ACCESS_CYCLES + 2;
    logic        sel;
    logic [15:0] wake_reg;
    logic [15:0] wake_next;
    logic [7:0]  wr_reg;
    logic [7:0]  wr_next;
    assign sel = !(&o_die_select_n) || !o_global_select_n;
    // The wake count saturates, so after reset it reads as long finished.
    always_comb
    begin
        wake_next = o_sleep_reset ? 16'h0 : wake_reg + {15'h0, wake_reg != 16'hffff};
        wr_next   = o_write_strobe_n ? 8'h0 : wr_reg + 8'h1;
    end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wake_reg <= 16'hffff;
            wr_reg   <= 8'h0;
        end
        else
        begin
            wake_reg <= wake_next;
            wr_reg   <= wr_next;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_ONE_DIE: assert property ($countones(~o_die_select_n) <= 1)
        else $error("two die selects low");
    AST_NO_MIX: assert property (!o_global_select_n |-> &o_die_select_n)
        else $error("global and die select together");
    AST_NO_FIGHT: assert property (o_dq_oe && sel |-> o_output_gate_n || !o_write_strobe_n)
        else $error("host drives while device may drive");
    AST_WRITE_DRIVES: assert property (sel && !o_write_strobe_n |-> o_dq_oe)
        else $error("write without host data");
    AST_ADDR_HOLD: assert property (sel && $past(sel) |-> $stable(o_addr))
        else $error("address moved inside an access");
    AST_READ_LAT: assert property (i_req_valid && o_req_ready && !o_sleep_reset
        && i_req_cmd == amc_pkg::AMC_CMD_READ |-> ##RSP_LAT o_rsp_valid)
        else $error("read answer late or missing");
    AST_WRITE_LEN: assert property ($rose(o_write_strobe_n) |-> wr_reg == WRITE_CYCLES + 1)
        else $error("write strobe length wrong");
    AST_SLEEP_IDLE: assert property (o_sleep_reset |-> sel == 1'b0 && o_write_strobe_n)
        else $error("select or strobe active in sleep");
    AST_WAKE_WAIT: assert property (sel |-> wake_reg >= WAKE_CYCLES)
        else $error("access too soon after wake");
    AST_TRUST_SLEEP: assert property (o_sleep_reset |=> !o_flag_trusted)
        else $error("flag trusted during sleep");
endmodule : amc_host_properties

//--- tb/amc_mem_model.sv
// Behavioural model of the four-die byte-wide memory module.
`timescale 1ns/100ps
module amc_mem_model #(
    parameter int DELAY_NS = 40
) (
    input  wire logic        i_err_en,
    input  wire logic [22:0] i_err_key,
    input  wire logic [22:0] i_addr,
    input  wire logic [3:0]  i_die_select_n,
    input  wire logic        i_global_select_n,
    input  wire logic        i_write_strobe_n,
    input  wire logic        i_output_gate_n,
    input  wire logic        i_sleep_reset,
    input  wire logic [7:0]  i_host_dq,
    input  wire logic        i_host_oe,
    output logic [7:0]       o_dq,
    output logic             o_multi_error_flag,
    output logic [3:0]       o_touched
);
    logic [8:0]  mem [logic [22:0]];
    logic [1:0]  die;
    logic        sel;
    logic [22:0] key;
    logic [7:0]  word;
    logic [7:0]  last;
    wire         oe_late;
    wire  [7:0]  data_late;
    wire         dev_oe;
    always_comb
    begin
        sel = 1'b0;
        die = 2'h0;
        if (!i_sleep_reset && !i_global_select_n && i_die_select_n == 4'hf)
        begin
            sel = 1'b1;
            die = {i_addr[22], i_addr[22] ^ i_addr[21]};
        end
        else if (!i_sleep_reset && i_global_select_n && $countones(~i_die_select_n) == 1)
        begin
            sel = 1'b1;
            for (int i = 0; i < 4; i++)
                if (!i_die_select_n[i])
                    die = 2'(i);
        end
    end
    assign key = {die, i_addr[20:0]};
    // Looked up on an address change; a write refreshes it at once.
    always @(key)
        word = mem.exists(key) ? mem[key][7:0] : 8'h00;
    assign #(DELAY_NS) oe_late = sel && !i_output_gate_n && i_write_strobe_n;
    assign #(DELAY_NS) data_late = word;
    assign dev_oe = oe_late && sel && !i_output_gate_n && i_write_strobe_n;
    // An undriven bus shows the inverse of its last level, never a stale copy.
    always @(i_host_dq, data_late, i_host_oe, dev_oe)
        if (i_host_oe)
            last = i_host_dq;
        else if (dev_oe)
            last = data_late;
    assign o_dq = i_host_oe ? i_host_dq : dev_oe ? data_late : ~last;
    assign o_multi_error_flag = !(dev_oe && i_err_en && key == i_err_key);
    always @(posedge i_write_strobe_n)
        if (sel)
        begin
            mem[key] = {^o_dq, o_dq};
            word = o_dq;
        end
    always @(sel, die, i_sleep_reset)
        if (i_sleep_reset)
            o_touched = 4'h0;
        else if (sel)
            o_touched[die] = 1'b1;
endmodule : amc_mem_model

//--- tb/amc_host_tb.sv
// Self-checking testbench for the memory port controller.
`timescale 1ns/100ps
module amc_host_tb;
    localparam int LIMIT = 2000;
    localparam int PWR_CYC = 10;
    logic              i_clk = 1'b0;
    logic              i_rst = 1'b1;
    logic              req_valid = 1'b0;
    amc_pkg::amc_cmd_t req_cmd = amc_pkg::AMC_CMD_READ;
    logic              req_global = 1'b0;
    logic [22:0]       req_addr = 23'h0;
    logic [7:0]        req_wdata = 8'h0;
    logic              err_en = 1'b0;
    logic [22:0]       err_key = 23'h0;
    logic              req_ready, rsp_valid, rsp_err, trusted, gsel_n, wstb_n, gate_n, sleep;
    logic              dq_oe, multi_error_flag;
    logic [7:0]        rdata, host_dq, dq_bus;
    logic [22:0]       addr;
    logic [3:0]        dsel_n, touched;
    int                n_fail = 0;
    int                n_checks = 0;
    always #2 i_clk = ~i_clk;
    amc_host #(.POWERUP_CYCLES(PWR_CYC), .WAKE_CYCLES(20)) u_amc_host (.i_clk(i_clk),
        .i_rst(i_rst), .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_cmd(req_cmd),
        .i_req_global(req_global), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
        .o_rsp_valid(rsp_valid), .o_rsp_rdata(rdata), .o_rsp_multi_err(rsp_err),
        .o_flag_trusted(trusted), .o_addr(addr), .o_die_select_n(dsel_n),
        .o_global_select_n(gsel_n), .o_write_strobe_n(wstb_n), .o_output_gate_n(gate_n),
        .o_sleep_reset(sleep), .i_dq(dq_bus), .o_dq(host_dq), .o_dq_oe(dq_oe),
        .i_multi_error_flag(multi_error_flag));
    amc_mem_model u_amc_mem_model (.i_err_en(err_en), .i_err_key(err_key), .i_addr(addr),
        .i_die_select_n(dsel_n), .i_global_select_n(gsel_n), .i_write_strobe_n(wstb_n),
        .i_output_gate_n(gate_n), .i_sleep_reset(sleep), .i_host_dq(host_dq),
        .i_host_oe(dq_oe), .o_dq(dq_bus), .o_multi_error_flag(multi_error_flag), .o_touched(touched));
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check
    task automatic hang(input string what);
        check(1'b0, what);
        end_of_test();
    endtask : hang
    task automatic wait_ready();
        int k = 0;
        while (req_ready !== 1'b1)
        begin
            @(negedge i_clk);
            k++;
            if (k > LIMIT)
                hang("ready never came");
        end
    endtask : wait_ready
    task automatic send(input amc_pkg::amc_cmd_t c, input logic g, input logic [22:0] a,
                        input logic [7:0] d);
        @(negedge i_clk);
        req_cmd = c;
        req_global = g;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        wait_ready();
        @(negedge i_clk);
        req_valid = 1'b0;
    endtask : send
    task automatic rd(input logic g, input logic [22:0] a, input logic [7:0] x, input logic e);
        int k = 0;
        send(amc_pkg::AMC_CMD_READ, g, a, 8'h00);
        while (rsp_valid !== 1'b1)
        begin
            @(posedge i_clk);
            #1;
            k++;
            if (k > 100)
                hang("no read answer");
        end
        check(rdata === x && rsp_err === e, "read data or error flag");
    endtask : rd
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic s_dies();
        logic [1:0] top [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        for (int d = 0; d < 4; d++)
        begin
            send(amc_pkg::AMC_CMD_WRITE, 1'b1, {top[d], 21'h1ffffc + 21'(d)}, 8'ha0 + 8'(d));
            rd(1'b0, {2'(d), 21'h1ffffc + 21'(d)}, 8'ha0 + 8'(d), 1'b0);
        end
        send(amc_pkg::AMC_CMD_WRITE, 1'b0, {2'h2, 21'h000000}, 8'h5a);
        rd(1'b1, {2'h3, 21'h000000}, 8'h5a, 1'b0);
        rd(1'b1, {2'h0, 21'h1ffffc}, 8'ha0, 1'b0);
    endtask : s_dies
    task automatic s_flag();
        err_en = 1'b1;
        err_key = {2'h3, 21'h1fffff};
        rd(1'b0, {2'h3, 21'h1fffff}, 8'ha3, 1'b1);
        rd(1'b1, {2'h1, 21'h1ffffd}, 8'ha1, 1'b0);
        err_en = 1'b0;
    endtask : s_flag
    task automatic s_sleep();
        logic seen = 1'b0;
        send(amc_pkg::AMC_CMD_SLEEP, 1'b0, 23'h0, 8'h00);
        repeat (3) @(negedge i_clk);
        check(sleep === 1'b1 && trusted === 1'b0, "sleep not entered");
        send(amc_pkg::AMC_CMD_READ, 1'b0, 23'h0, 8'h00);
        repeat (40)
        begin
            @(posedge i_clk);
            #1;
            seen = seen | (rsp_valid === 1'b1);
        end
        check(!seen, "read acted during sleep");
        send(amc_pkg::AMC_CMD_WAKE, 1'b0, 23'h0, 8'h00);
        wait_ready();
        check(sleep === 1'b0 && trusted === 1'b1 && touched === 4'hf, "wake init");
        rd(1'b0, {2'h1, 21'h1ffffd}, 8'ha1, 1'b0);
    endtask : s_sleep
    initial
    begin
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        for (int k = 0; k < PWR_CYC; k++)
        begin
            @(negedge i_clk);
            check(dsel_n === 4'hf && gsel_n === 1'b1 && wstb_n === 1'b1, "start-up");
        end
        wait_ready();
        check(touched === 4'hf && trusted === 1'b1, "dies not touched at start");
        s_dies();
        s_flag();
        s_sleep();
        end_of_test();
    end
endmodule : amc_host_tb
bind amc_host amc_host_properties #(.WAKE_CYCLES(WAKE_CYCLES), .ACCESS_CYCLES(ACCESS_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES)) u_amc_host_properties (.i_clk(i_clk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_cmd(i_req_cmd),
    .o_rsp_valid(o_rsp_valid), .o_flag_trusted(o_flag_trusted), .o_addr(o_addr),
    .o_die_select_n(o_die_select_n), .o_global_select_n(o_global_select_n),
    .o_write_strobe_n(o_write_strobe_n), .o_output_gate_n(o_output_gate_n),
    .o_sleep_reset(o_sleep_reset), .o_dq_oe(o_dq_oe));
